// ### verilog/pbc_pkg.sv
// constants for the basic management control register block
package pbc_pkg;
  // management frame layout
  localparam logic [4:0] PBC_REG_ADDR = 5'h00;
  localparam logic [1:0] PBC_OP_READ = 2'h2;
  localparam logic [1:0] PBC_OP_WRITE = 2'h1;
  localparam logic [5:0] PBC_PRE_MIN = 6'h20; // 32 preamble ones
  localparam logic [3:0] PBC_DATA_LAST = 4'hF;
  localparam logic [3:0] PBC_ADDR_LAST = 4'h9;
  localparam logic [4:0] PBC_ISO_STRAP_ADDR = 5'h00;

  // control register field positions
  localparam int PBC_B_SRST = 15;
  localparam int PBC_B_LOOP = 14;
  localparam int PBC_B_SPEED = 13;
  localparam int PBC_B_AUTONEG_HW_ENABLE_PIN = 12;
  localparam int PBC_B_PDOWN = 11;
  localparam int PBC_B_ISO = 10;
  localparam int PBC_B_AN_RST = 9;
  localparam int PBC_B_DUPLEX = 8;
  localparam int PBC_B_COLT = 7;

  // reset values of the stored fields
  localparam logic PBC_RST_AN_BIT = 1'b1;
  localparam logic PBC_RST_DUPLEX = 1'b0;

  // timing
  localparam int PBC_CLK_NS = 50;
  localparam int PBC_SRST_US = 1000; // soft reset about 1 ms
  localparam int PBC_SRST_CYC = (PBC_SRST_US * 1000) / PBC_CLK_NS;
  localparam int PBC_BIT_NS_100 = 10;
  localparam int PBC_BIT_NS_10 = 100;
  localparam int PBC_COL_RISE_BT = 512;
  localparam int PBC_COL_FALL_BT = 4;
  // longest times round down, never below one cycle
  localparam int PBC_COL_RISE_CYC = (PBC_COL_RISE_BT * PBC_BIT_NS_100) / PBC_CLK_NS;
  localparam int PBC_COL_FALL_CYC_10 = (PBC_COL_FALL_BT * PBC_BIT_NS_10) / PBC_CLK_NS;
  localparam logic [1:0] PBC_STRAP_WAIT = 2'h2;

  // management receiver states
  typedef enum logic [2:0] {
    PBC_S_PRE = 3'b000,
    PBC_S_ST = 3'b001,
    PBC_S_OP = 3'b010,
    PBC_S_ADR = 3'b011,
    PBC_S_TA = 3'b100,
    PBC_S_DAT = 3'b101
  } pbc_state_e;
endpackage

// ### verilog/pbc_basic_control.sv
// management control register of the transceiver with its serial management slave
`timescale 1ns/1ns
module pbc_basic_control import pbc_pkg::*; #(
  parameter int SRST_CYCLES = PBC_SRST_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // straps and hardware pins
  input wire logic [4:0] strap_phy_addr,
  input wire logic strap_autoneg,
  input wire logic strap_speed_100,
  input wire logic autoneg_hw_enable_pin,
  // mac side
  input wire logic mii_tx_en,
  output logic mii_col,
  output logic mii_out_en,
  // control towards the rest of the transceiver
  output logic soft_reset_busy,
  output logic autoneg_active,
  output logic autoneg_restart,
  output logic forced_speed_100,
  output logic forced_full_duplex,
  output logic loopback_on,
  output logic power_down,
  output logic pad_force
);
  // refuse a reset length that the 24-bit timer cannot hold
  if (SRST_CYCLES < 1 || SRST_CYCLES > 32'h00FF_FFFF) begin : g_bad_srst
    $error("SRST_CYCLES out of range");
  end
  // input synchronisers; first stage feeds only the second
  logic mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2, tx_s1, tx_s2, anpin_s1, anpin_s2;
  logic [7:0] strap_s1, strap_s2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mdc_s1 <= 1'b0;
      mdc_s2 <= 1'b0;
      mdc_s3 <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
      tx_s1 <= 1'b0;
      tx_s2 <= 1'b0;
      anpin_s1 <= 1'b1;
      anpin_s2 <= 1'b1;
      strap_s1 <= 8'h00;
      strap_s2 <= 8'h00;
    end else begin
      mdc_s1 <= mdc;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
      mdio_s1 <= mdio_in;
      mdio_s2 <= mdio_s1;
      tx_s1 <= mii_tx_en;
      tx_s2 <= tx_s1;
      anpin_s1 <= autoneg_hw_enable_pin;
      anpin_s2 <= anpin_s1;
      strap_s1 <= {strap_speed_100, strap_autoneg, 1'b0, strap_phy_addr};
      strap_s2 <= strap_s1;
    end
  end
  wire mdc_rise = mdc_s2 & ~mdc_s3;
  // strap capture a few cycles after reset release, once synchronisers hold pin values
  logic [1:0] strap_cnt_reg;
  wire strap_load = (strap_cnt_reg == PBC_STRAP_WAIT);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_cnt_reg <= 2'h0;
    end else if (strap_cnt_reg != 2'h3) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
    end
  end
  // stored control fields
  logic loop_reg, speed_reg, an_bit_reg, an_written_reg, an_strap_reg, pdown_reg;
  logic iso_reg, duplex_reg, colt_reg, srst_reg, an_rst_reg;
  logic [4:0] phy_addr_reg;
  logic [23:0] srst_cnt_reg;
  logic wr_stb_reg;
  logic [15:0] wr_data_reg;
  // effective negotiation enable: pin low wins, else last write or strap
  wire an_eff = anpin_s2 & (an_written_reg ? an_bit_reg : an_strap_reg);
  // register read image; reserved bits and restart bit read zero
  function automatic logic [15:0] ctl_word(input logic sr, input logic lb, input logic sp, input logic an,
                                            input logic pd, input logic iso, input logic dx, input logic ct);
    logic [15:0] w;
    w = 16'h0000;
    w[PBC_B_SRST] = sr;
    w[PBC_B_LOOP] = lb;
    w[PBC_B_SPEED] = sp;
    w[PBC_B_AUTONEG_HW_ENABLE_PIN] = an;
    w[PBC_B_PDOWN] = pd;
    w[PBC_B_ISO] = iso;
    w[PBC_B_DUPLEX] = dx;
    w[PBC_B_COLT] = ct;
    return w;
  endfunction
  wire [15:0] rd_word = ctl_word(srst_reg, loop_reg, speed_reg, an_written_reg ? an_bit_reg : PBC_RST_AN_BIT,
                                 pdown_reg, iso_reg, duplex_reg, colt_reg);
  // management frame receiver and read driver, alive in every mode
  pbc_state_e st_reg;
  logic [5:0] pre_cnt_reg;
  logic [3:0] bit_cnt_reg;
  logic [15:0] sh_reg;
  logic rd_op_reg, hit_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= PBC_S_PRE;
      pre_cnt_reg <= 6'h00;
      bit_cnt_reg <= 4'h0;
      sh_reg <= 16'h0000;
      rd_op_reg <= 1'b0;
      hit_reg <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
      wr_stb_reg <= 1'b0;
      wr_data_reg <= 16'h0000;
    end else begin
      wr_stb_reg <= 1'b0;
      if (mdc_rise) begin
        case (st_reg)
          PBC_S_PRE: begin
            if (mdio_s2) begin
              if (pre_cnt_reg != PBC_PRE_MIN) begin
                pre_cnt_reg <= pre_cnt_reg + 6'h01;
              end
            end else begin
              pre_cnt_reg <= 6'h00;
              if (pre_cnt_reg == PBC_PRE_MIN) begin
                st_reg <= PBC_S_ST;
              end
            end
          end
          PBC_S_ST: begin
            bit_cnt_reg <= 4'h0;
            st_reg <= mdio_s2 ? PBC_S_OP : PBC_S_PRE;
          end
          PBC_S_OP: begin
            sh_reg <= {sh_reg[14:0], mdio_s2};
            if (bit_cnt_reg == 4'h1) begin
              bit_cnt_reg <= 4'h0;
              rd_op_reg <= ({sh_reg[0], mdio_s2} == PBC_OP_READ);
              if ({sh_reg[0], mdio_s2} == PBC_OP_READ || {sh_reg[0], mdio_s2} == PBC_OP_WRITE) begin
                st_reg <= PBC_S_ADR;
              end else begin
                st_reg <= PBC_S_PRE;
              end
            end else begin
              bit_cnt_reg <= 4'h1;
            end
          end
          PBC_S_ADR: begin
            sh_reg <= {sh_reg[14:0], mdio_s2};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == PBC_ADDR_LAST) begin
              bit_cnt_reg <= 4'h0;
              hit_reg <= (sh_reg[8:4] == phy_addr_reg);
              st_reg <= PBC_S_TA;
            end
          end
          PBC_S_TA: begin
            if (bit_cnt_reg == 4'h0) begin
              bit_cnt_reg <= 4'h1;
              mdio_out <= 1'b0;
              mdio_oe <= rd_op_reg & hit_reg;
            end else begin
              bit_cnt_reg <= 4'h0;
              st_reg <= PBC_S_DAT;
              // only address zero is mapped here, others read zero
              sh_reg <= (sh_reg[4:0] == PBC_REG_ADDR) ? {rd_word[14:0], 1'b0} : 16'h0000;
              mdio_out <= (sh_reg[4:0] == PBC_REG_ADDR) ? rd_word[15] : 1'b0;
              hit_reg <= hit_reg & (sh_reg[4:0] == PBC_REG_ADDR);
            end
          end
          PBC_S_DAT: begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (rd_op_reg) begin
              mdio_out <= sh_reg[15];
              sh_reg <= {sh_reg[14:0], 1'b0};
            end else begin
              sh_reg <= {sh_reg[14:0], mdio_s2};
            end
            if (bit_cnt_reg == PBC_DATA_LAST) begin
              mdio_oe <= 1'b0;
              mdio_out <= 1'b0;
              st_reg <= PBC_S_PRE;
              pre_cnt_reg <= 6'h00;
              wr_stb_reg <= ~rd_op_reg & hit_reg;
              wr_data_reg <= {sh_reg[14:0], mdio_s2};
            end
          end
          default: begin
            st_reg <= PBC_S_PRE;
            mdio_oe <= 1'b0;
          end
        endcase
      end
    end
  end
  // soft reset timer; a second write of one while busy is ignored
  wire srst_start = wr_stb_reg & ~srst_reg & wr_data_reg[PBC_B_SRST];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      srst_reg <= 1'b0;
      srst_cnt_reg <= 24'h000000;
    end else if (srst_start) begin
      srst_reg <= 1'b1;
      srst_cnt_reg <= 24'(SRST_CYCLES - 1);
    end else if (srst_reg) begin
      if (srst_cnt_reg == 24'h000000) begin
        srst_reg <= 1'b0;
      end else begin
        srst_cnt_reg <= srst_cnt_reg - 24'h000001;
      end
    end
  end
  // control field writes; straps are not reloaded by soft reset
  wire wr_ok = wr_stb_reg & ~srst_reg & ~wr_data_reg[PBC_B_SRST];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_reg <= 1'b0;
      speed_reg <= 1'b0;
      an_bit_reg <= PBC_RST_AN_BIT;
      an_written_reg <= 1'b0;
      an_strap_reg <= 1'b0;
      pdown_reg <= 1'b0;
      iso_reg <= 1'b0;
      duplex_reg <= PBC_RST_DUPLEX;
      colt_reg <= 1'b0;
      phy_addr_reg <= 5'h00;
      an_rst_reg <= 1'b0;
    end else begin
      an_rst_reg <= 1'b0;
      if (strap_load) begin
        phy_addr_reg <= strap_s2[4:0];
        an_strap_reg <= strap_s2[6];
        speed_reg <= strap_s2[7];
        iso_reg <= (strap_s2[4:0] == PBC_ISO_STRAP_ADDR);
      end else if (srst_start) begin
        // soft reset returns the runtime modes to normal operation
        loop_reg <= 1'b0;
        pdown_reg <= 1'b0;
        iso_reg <= 1'b0;
        duplex_reg <= PBC_RST_DUPLEX;
        colt_reg <= 1'b0;
      end else if (wr_ok) begin
        loop_reg <= wr_data_reg[PBC_B_LOOP];
        speed_reg <= wr_data_reg[PBC_B_SPEED];
        if (anpin_s2) begin
          an_bit_reg <= wr_data_reg[PBC_B_AUTONEG_HW_ENABLE_PIN];
          an_written_reg <= 1'b1;
        end
        pdown_reg <= wr_data_reg[PBC_B_PDOWN];
        iso_reg <= wr_data_reg[PBC_B_ISO];
        an_rst_reg <= wr_data_reg[PBC_B_AN_RST] & an_eff;
        duplex_reg <= wr_data_reg[PBC_B_DUPLEX];
        colt_reg <= wr_data_reg[PBC_B_COLT];
      end
    end
  end
  // registered mode outputs for the rest of the transceiver
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_reset_busy <= 1'b0;
      autoneg_active <= 1'b0;
      autoneg_restart <= 1'b0;
      forced_speed_100 <= 1'b0;
      forced_full_duplex <= 1'b0;
      loopback_on <= 1'b0;
      power_down <= 1'b0;
      pad_force <= 1'b0;
      mii_out_en <= 1'b0;
    end else begin
      soft_reset_busy <= srst_reg;
      autoneg_active <= an_eff;
      autoneg_restart <= an_rst_reg;
      forced_speed_100 <= ~an_eff & speed_reg;
      forced_full_duplex <= ~an_eff & duplex_reg;
      loopback_on <= loop_reg;
      power_down <= pdown_reg;
      pad_force <= pdown_reg;
      mii_out_en <= ~iso_reg & ~pdown_reg;
    end
  end
  // collision test: synchroniser plus one register, three cycles end to end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mii_col <= 1'b0;
    end else begin
      mii_col <= tx_s2 & colt_reg & loop_reg & ~iso_reg;
    end
  end
  // assertions share one clock and drop out during chip reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  localparam int COL_RISE_MAX = PBC_COL_RISE_CYC; // local copy keeps the delay bound a plain constant
  sequence s_srst_write;
    wr_stb_reg && !srst_reg && wr_data_reg[PBC_B_SRST];
  endsequence
  sequence s_tx_seen;
    $rose(tx_s2) && colt_reg && loop_reg && !iso_reg;
  endsequence

  logic [23:0] a_busy_cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_busy_cnt <= 24'h000000;
    end else begin
      a_busy_cnt <= srst_reg ? a_busy_cnt + 24'h000001 : 24'h000000;
    end
  end

  a_srst_sets: assert property (s_srst_write |=> srst_reg ##1 soft_reset_busy)
    else $error("soft reset did not start");
  a_srst_ends: assert property (srst_reg |-> a_busy_cnt <= 24'(SRST_CYCLES))
    else $error("soft reset ran too long");
  a_srst_blocks: assert property (srst_reg && wr_stb_reg |=> $stable(loop_reg) && $stable(iso_reg) && $stable(duplex_reg))
    else $error("write accepted during soft reset");
  a_zero_noop: assert property (wr_stb_reg && !srst_reg && !wr_data_reg[PBC_B_SRST] |=> !srst_reg)
    else $error("zero write started reset");
  a_loop_write: assert property (wr_ok |=> loop_reg == $past(wr_data_reg[PBC_B_LOOP]) ##1 loopback_on == loop_reg)
    else $error("loop-back not taken");
  a_speed_gate: assert property (an_eff |=> !forced_speed_100)
    else $error("speed forced while negotiating");
  a_pin_wins: assert property (!anpin_s2 |=> !autoneg_active)
    else $error("negotiation active with pin low");
  a_an_locked: assert property (!anpin_s2 && wr_ok |=> $stable(an_bit_reg) && $stable(an_written_reg))
    else $error("negotiation bit written under pin disable");
  a_restart_gate: assert property (autoneg_restart |-> $past(an_eff, 2))
    else $error("restart with negotiation disabled");
  a_read_zero: assert property (rd_word[PBC_B_AN_RST] == 1'b0 && rd_word[6:0] == 7'h00)
    else $error("reserved or restart bit read nonzero");
  a_col_rise: assert property (s_tx_seen |-> ##[1:COL_RISE_MAX] mii_col)
    else $error("collision late");
  a_col_fall: assert property ($fell(tx_s2) |=> !mii_col [*2])
    else $error("collision not dropped");
  a_iso_oe: assert property (iso_reg |=> !mii_out_en)
    else $error("mii drives while isolated");

endmodule // pbc_basic_control

// ### sim/pbc_mgmt_model.sv
// station management controller model sending clause 22 frames
`timescale 1ns/1ns
module pbc_mgmt_model import pbc_pkg::*; (
  // clock
  input wire logic clk,
  // management pins
  output logic mdc,
  output logic mdio_drv,
  input wire logic mdio_line
);
  localparam int HALF = 4; // clk per mdc phase, above the three the slave needs

  // idle: clock stands still, line released to its pull-up
  initial begin
    mdc = 1'b0;
    mdio_drv = 1'b1;
  end

  // one bit slot: data set while mdc low, line sampled at the rising edge
  task automatic slot(input logic d, output logic s);
    @(negedge clk);
    mdc = 1'b0;
    mdio_drv = d;
    repeat (HALF) @(negedge clk);
    s = mdio_line;
    mdc = 1'b1;
    repeat (HALF - 1) @(negedge clk);
  endtask

  // whole frame; a read sends ones so the slave owns turnaround and data
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rdata);
    logic [31:0] hdr;
    logic s;
    hdr = {2'b01, rd ? PBC_OP_READ : PBC_OP_WRITE, phy, ra, rd ? 2'b11 : 2'b10, wd};
    for (int i = 0; i < 32; i++)
      slot(1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      slot(hdr[i], s);
      if (i < 16) rdata[i] = s;
    end
    @(negedge clk);
    mdc = 1'b0;
    mdio_drv = 1'b1;
  endtask
endmodule // pbc_mgmt_model

// ### sim/phy_basic_control_register_tb.sv
// self-checking bench for the basic control register block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module phy_basic_control_register_tb import pbc_pkg::*;;
  localparam int SRST = 2000; // longer than two frames so a running reset can be probed
  logic clk, rst, mdc, mdio_drv, mdio_out, mdio_oe, mdio_in, strap_autoneg, strap_speed_100;
  logic autoneg_hw_enable_pin, mii_tx_en, mii_col, mii_out_en, soft_reset_busy, autoneg_active;
  logic autoneg_restart, forced_speed_100, forced_full_duplex, loopback_on, power_down, pad_force;
  logic [4:0] strap_phy_addr, phy;
  logic m_loop, m_spd, m_an, m_pd, m_iso, m_dx, m_ct, m_wr;
  logic [15:0] q, dd;
  int errors, check_count, cycles, busy_until, restarts, r0;

  // released line rests high on its pull-up
  assign mdio_in = mdio_oe ? mdio_out : mdio_drv;

  pbc_basic_control #(.SRST_CYCLES(SRST)) pbc_basic_control_inst (.clk, .rst, .mdc, .mdio_in, .mdio_out,
    .mdio_oe, .strap_phy_addr, .strap_autoneg, .strap_speed_100, .autoneg_hw_enable_pin, .mii_tx_en,
    .mii_col, .mii_out_en, .soft_reset_busy, .autoneg_active, .autoneg_restart, .forced_speed_100,
    .forced_full_duplex, .loopback_on, .power_down, .pad_force);
  pbc_mgmt_model pbc_mgmt_model_inst (.clk, .mdc, .mdio_drv, .mdio_line(mdio_in));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // cycle count, hang limit and restart pulse count
  always @(posedge clk) begin
    cycles++;
    if (autoneg_restart === 1'b1) restarts++;
    if (cycles == 80000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // effective negotiation: strap until first accepted write, pin always wins
  function automatic logic an_eff();
    return (m_wr ? m_an : strap_autoneg) & autoneg_hw_enable_pin;
  endfunction

  task automatic do_reset(input logic [4:0] a);
    strap_phy_addr = a;
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    phy = a;
    m_loop = 1'b0;
    m_spd = strap_speed_100;
    m_an = 1'b1;
    m_pd = 1'b0;
    m_iso = (a == 5'h00);
    m_dx = 1'b0;
    m_ct = 1'b0;
    m_wr = 1'b0;
    busy_until = 0;
    repeat (8) @(negedge clk);
  endtask

  // write frame plus model update; soft reset keeps speed and negotiation
  task automatic wr(input logic [15:0] d);
    pbc_mgmt_model_inst.frame(1'b0, phy, PBC_REG_ADDR, d, q);
    if (cycles >= busy_until && d[PBC_B_SRST]) begin
      busy_until = cycles + SRST;
      {m_loop, m_pd, m_iso, m_dx, m_ct} = 5'h00;
    end else if (cycles >= busy_until) begin
      {m_loop, m_spd, m_pd, m_iso, m_dx, m_ct} = {d[14:13], d[11:10], d[8:7]};
      if (autoneg_hw_enable_pin) begin
        m_an = d[PBC_B_AUTONEG_HW_ENABLE_PIN];
        m_wr = 1'b1;
      end
    end
    repeat (8) @(negedge clk);
  endtask

  // read back the register and compare every control output except autoneg_restart
  task automatic chk_reg();
    logic [15:0] e;
    e = {cycles < busy_until, m_loop, m_spd, m_an, m_pd, m_iso, 1'b0, m_dx, m_ct, 7'h00};
    pbc_mgmt_model_inst.frame(1'b1, phy, PBC_REG_ADDR, 16'hFFFF, q);
    `CHK("basic_control", e, q)
    `CHK("soft_reset_busy", e[15], soft_reset_busy)
    `CHK("autoneg_active", an_eff(), autoneg_active)
    `CHK("forced_speed_100", m_spd & ~an_eff(), forced_speed_100)
    `CHK("forced_full_duplex", m_dx & ~an_eff(), forced_full_duplex)
    `CHK("loopback_on", m_loop, loopback_on)
    `CHK("power_down", m_pd, power_down)
    `CHK("pad_force", m_pd, pad_force)
    `CHK("mii_out_en", ~(m_iso | m_pd), mii_out_en)
  endtask

  // collision answer to a transmit burst
  task automatic col_chk();
    mii_tx_en = 1'b1;
    repeat (6) @(negedge clk);
    `CHK("mii_col high", m_ct & m_loop & ~m_iso, mii_col)
    mii_tx_en = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("mii_col low", 1'b0, mii_col)
  endtask

  initial begin
    rst = 1'b1;
    strap_phy_addr = 5'h05;
    strap_autoneg = 1'b1;
    strap_speed_100 = 1'b1;
    autoneg_hw_enable_pin = 1'b1;
    mii_tx_en = 1'b0;
    void'($urandom(86));
    do_reset(5'h05);
    chk_reg();
    wr(16'h40FF);
    chk_reg();
    col_chk();
    wr(16'h4480);
    col_chk();
    chk_reg();
    wr(16'h0100);
    chk_reg();
    r0 = restarts;
    wr(16'h2200);
    wr(16'h1000);
    `CHK("restart while disabled", r0, restarts)
    wr(16'h1200);
    `CHK("restart pulses", r0 + 1, restarts)
    autoneg_hw_enable_pin = 1'b0;
    wr(16'h0200);
    chk_reg();
    `CHK("restart while pin low", r0 + 1, restarts)
    autoneg_hw_enable_pin = 1'b1;
    wr(16'h0800);
    chk_reg();
    // random settings, no reset or restart bit
    repeat (6) begin
      dd = 16'($urandom) & 16'h7DFF;
      if (!dd[PBC_B_LOOP]) dd[PBC_B_COLT] = 1'b0;
      wr(dd);
      chk_reg();
      col_chk();
    end
    // foreign address and foreign register
    wr(16'h0000);
    pbc_mgmt_model_inst.frame(1'b0, phy ^ 5'h01, PBC_REG_ADDR, 16'h4000, q);
    pbc_mgmt_model_inst.frame(1'b1, phy, 5'h01, 16'hFFFF, q);
    `CHK("other register", 16'h0000, q)
    chk_reg();
    // soft reset with a write ignored while it runs
    wr(16'h0900);
    wr(16'hC480);
    chk_reg();
    wr(16'h4000);
    chk_reg();
    while (cycles < busy_until + 10) @(negedge clk);
    chk_reg();
    // chip reset with all-zero address strap and a random speed strap
    strap_speed_100 = 1'($urandom);
    do_reset(5'h00);
    chk_reg();
    col_chk();
    wr(16'h0000);
    chk_reg();
    // negotiation strap low: bit 12 still reads one, effective enable follows strap
    strap_autoneg = 1'b0;
    do_reset(5'h05);
    chk_reg();
    summarize();
  end
endmodule // phy_basic_control_register_tb
